// ==== verilog/usart_datapath.sv ====
// serial transmit and receive datapath with APB register access
// Notes on behaviour
// - tx buffer empty flag high while buffer empty, low while holding data.
// - empty-buffer request stays asserted while enabled and flag set.
// - data register write loads the buffer, clearing the empty flag; here the write is ignored while the transmitter is off.
// - done flag sets when frame leaves shifter with buffer empty.
// - done flag clears on interrupt service or writing one.
// - done request raised when enabled and done flag sets.
// - parity bit inserted after last data bit, before stop bits.
// - transmit disable waits for empty shifter and buffer, then releases pin.
// - receive enable takes over the serial input pin.
// - synchronous mode uses the external clock pin as bit clock.
// - reception starts on valid start bit, samples up to first stop.
// - at first stop bit the frame moves into the receive buffer.
// - unused upper data bits of short characters read as zero.
// - ninth bit and error flags travel with each frame, read first.
// - frame is start, data lsb first, optional parity, stop bits.
// - buffer moves to shifter when idle or right after last stop.
// - parity is xor of data bits, inverted for odd.
// - receive done flag reads one while unread data remains.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module usart_datapath (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pin,
    input wire logic ext_bit_clock_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic serial_in_owned,
    output logic irq_tx_empty,
    output logic irq_tx_done,
    output logic irq_rx_done,
    input wire logic tx_done_ack
);
    logic rx_ie_q, txc_ie_q, udre_ie_q, rx_en_q, tx_en_q, csz2_q, tx_ninth_q;
    logic sync_q, par_en_q, par_odd_q, stop2_q;
    logic [1:0] csz_lo_q;
    logic [15:0] baud_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [3:0] nbits;
    logic setup, acc, wr_data, rd_data, wr_stat, wr_b, wr_c, wr_baud, mapped;
    logic rxi_1_q, rxi_2_q, xck_1_q, xck_2_q, xck_3_q, x_rise, x_fall;

    // character length in data bits
    assign nbits = ({csz2_q, csz_lo_q} == usart_pkg::CSZ_NINE) ? usart_pkg::NBITS_NINE :
        usart_pkg::NBITS_BASE + {2'b00, csz_lo_q};

    // bus phases: decode taken at setup, effects at the access edge
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign pready = acc;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q && acc;
    assign wr_data = acc && pwrite && paddr == usart_pkg::OFS_DATA;
    assign rd_data = acc && !pwrite && paddr == usart_pkg::OFS_DATA;
    assign wr_stat = acc && pwrite && paddr == usart_pkg::OFS_STAT_A;
    assign wr_b = acc && pwrite && paddr == usart_pkg::OFS_CTRL_B;
    assign wr_c = acc && pwrite && paddr == usart_pkg::OFS_CTRL_C;
    assign wr_baud = acc && pwrite && paddr == usart_pkg::OFS_BAUD;
    assign mapped = paddr == usart_pkg::OFS_DATA || paddr == usart_pkg::OFS_STAT_A ||
        paddr == usart_pkg::OFS_CTRL_B || paddr == usart_pkg::OFS_CTRL_C ||
        paddr == usart_pkg::OFS_BAUD;

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxi_1_q <= 1'b1;
            rxi_2_q <= 1'b1;
            xck_1_q <= 1'b0;
            xck_2_q <= 1'b0;
            xck_3_q <= 1'b0;
        end else begin
            rxi_1_q <= serial_in_pin;
            rxi_2_q <= rxi_1_q;
            xck_1_q <= ext_bit_clock_pin;
            xck_2_q <= xck_1_q;
            xck_3_q <= xck_2_q;
        end
    end
    assign x_rise = xck_2_q && !xck_3_q;
    assign x_fall = !xck_2_q && xck_3_q;

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rx_ie_q, txc_ie_q, udre_ie_q, rx_en_q} <= usart_pkg::CTRL_B_RST[7:4];
            {tx_en_q, csz2_q, tx_ninth_q} <= {usart_pkg::CTRL_B_RST[3:2],
                usart_pkg::CTRL_B_RST[0]};
            {sync_q, par_en_q, par_odd_q, stop2_q} <= usart_pkg::CTRL_C_RST[6:3];
            csz_lo_q <= usart_pkg::CTRL_C_RST[2:1];
            baud_q <= usart_pkg::BAUD_RST;
        end else begin
            if (wr_b) begin
                rx_ie_q <= pwdata[usart_pkg::CTB_RX_IE];
                txc_ie_q <= pwdata[usart_pkg::CTB_TX_DONE_IE];
                udre_ie_q <= pwdata[usart_pkg::CTB_TX_EMPTY_IE];
                rx_en_q <= pwdata[usart_pkg::CTB_RX_EN];
                tx_en_q <= pwdata[usart_pkg::CTB_TX_EN];
                csz2_q <= pwdata[usart_pkg::CTB_CSZ2];
                tx_ninth_q <= pwdata[usart_pkg::CTB_TX_NINTH];
            end
            if (wr_c) begin
                sync_q <= pwdata[usart_pkg::CTC_SYNC];
                par_en_q <= pwdata[usart_pkg::CTC_PAR_EN];
                par_odd_q <= pwdata[usart_pkg::CTC_PAR_ODD];
                stop2_q <= pwdata[usart_pkg::CTC_STOP2];
                csz_lo_q <= pwdata[usart_pkg::CTC_CSZ_LO +: 2];
            end
            if (wr_baud)
                baud_q <= pwdata[15:0];
        end
    end

    // ---------------- transmitter ----------------
    logic [8:0] tx_buf_q;
    logic tx_buf_full_q, tx_inflight_q, tx_done_q, tx_drive_q, tx_out_q;
    logic [11:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic [15:0] tx_bcnt_q;
    logic tx_tick, tx_load, txc_set;

    // data bits lsb first, parity after the last data bit, ones for stops
    function automatic logic [11:0] tx_frame(input logic [8:0] d, input logic [3:0] n,
        input logic pen, input logic podd);
        logic [11:0] f;
        logic p;
        f = 12'hFFF;
        p = podd;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                f[i] = d[i];
                p = p ^ d[i];
            end
        end
        if (pen)
            f[n] = p;
        return f;
    endfunction

    // bit clock: pin rising edge in sync mode, divider otherwise
    assign tx_tick = sync_q ? x_rise : (tx_bcnt_q == 16'h0000);
    assign tx_load = tx_tick && tx_cnt_q == 4'h0 && tx_buf_full_q;
    assign txc_set = tx_tick && tx_cnt_q == 4'h0 && tx_inflight_q && !tx_buf_full_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_bcnt_q <= 16'h0000;
        else if (tx_bcnt_q == 16'h0000)
            tx_bcnt_q <= baud_q;
        else
            tx_bcnt_q <= tx_bcnt_q - 16'h0001;
    end

    // transmit buffer; a write only lands while the transmitter is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_q <= 9'h000;
            tx_buf_full_q <= 1'b0;
        end else if (wr_data && tx_en_q) begin
            tx_buf_q <= {tx_ninth_q, pwdata[7:0]};
            tx_buf_full_q <= 1'b1;
        end else if (tx_load) begin
            tx_buf_full_q <= 1'b0;
        end
    end

    // shifter: start bit goes out at load, rest of frame on later ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh_q <= 12'hFFF;
            tx_cnt_q <= 4'h0;
            tx_out_q <= 1'b1;
            tx_inflight_q <= 1'b0;
        end else if (tx_tick) begin
            if (tx_cnt_q != 4'h0) begin
                tx_out_q <= tx_sh_q[0];
                tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                tx_cnt_q <= tx_cnt_q - 4'h1;
            end else if (tx_load) begin
                tx_out_q <= 1'b0;
                tx_sh_q <= tx_frame(tx_buf_q, nbits, par_en_q, par_odd_q);
                tx_cnt_q <= nbits + {3'b000, par_en_q} + 4'h1 + {3'b000, stop2_q};
                tx_inflight_q <= 1'b1;
            end else begin
                tx_out_q <= 1'b1;
                tx_inflight_q <= 1'b0;
            end
        end
    end

    // done flag: a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_done_q <= 1'b0;
        else if (txc_set)
            tx_done_q <= 1'b1;
        else if (tx_done_ack || (wr_stat && pwdata[usart_pkg::STA_TX_DONE]))
            tx_done_q <= 1'b0;
    end

    // pin ownership lingers until shifter and buffer have drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_drive_q <= 1'b0;
        else if (tx_en_q)
            tx_drive_q <= 1'b1;
        else if (!tx_inflight_q && !tx_buf_full_q && !tx_load)
            tx_drive_q <= 1'b0;
    end
    assign serial_out_pin = tx_drive_q ? tx_out_q : 1'b1;
    assign serial_out_oe = tx_drive_q;
    assign irq_tx_empty = udre_ie_q && !tx_buf_full_q;
    assign irq_tx_done = txc_ie_q && tx_done_q;

    // ---------------- receiver ----------------
    usart_pkg::rx_state_e rx_st_q;
    logic [15:0] rx_bcnt_q;
    logic [10:0] rx_sh_q;
    logic [3:0] rx_idx_q, rx_last;
    logic rx_smp, rx_push, dor_pend_q, rx_bit;
    logic [8:0] rx_data;
    logic rx_fe, rx_pe;
    logic [11:0] fifo_q [usart_pkg::FIFO_DEPTH];
    logic rd_ptr_q, wr_ptr_q;
    logic [1:0] rx_cnt_q;
    logic [11:0] rx_head;

    assign serial_in_owned = rx_en_q;
    assign rx_bit = rxi_2_q;
    assign rx_smp = sync_q ? x_fall : (rx_bcnt_q == 16'h0000);
    assign rx_last = nbits + {3'b000, par_en_q};
    assign rx_push = rx_st_q == usart_pkg::RX_BITS && rx_smp && rx_idx_q == rx_last;

    // data masked to character length, parity and first-stop checks
    always_comb begin
        rx_data = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nbits))
                rx_data[i] = rx_sh_q[i];
        end
        rx_pe = par_en_q && (^rx_data ^ par_odd_q ^ rx_sh_q[nbits]);
        rx_fe = !rx_bit;
    end

    // start detection and bit sampling; a second stop is never sampled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q <= usart_pkg::RX_IDLE;
            rx_bcnt_q <= 16'h0000;
            rx_sh_q <= 11'h000;
            rx_idx_q <= 4'h0;
        end else begin
            rx_bcnt_q <= (rx_bcnt_q == 16'h0000) ? baud_q : rx_bcnt_q - 16'h0001;
            case (rx_st_q)
                usart_pkg::RX_IDLE: begin
                    rx_idx_q <= 4'h0;
                    if (rx_en_q && !rx_bit && sync_q && x_fall) begin
                        rx_st_q <= usart_pkg::RX_BITS;
                    end else if (rx_en_q && !rx_bit && !sync_q) begin
                        rx_st_q <= usart_pkg::RX_START;
                        rx_bcnt_q <= {1'b0, baud_q[15:1]};
                    end
                end
                usart_pkg::RX_START: begin
                    // mid-bit recheck rejects glitches as start bits
                    if (rx_smp)
                        rx_st_q <= rx_bit ? usart_pkg::RX_IDLE : usart_pkg::RX_BITS;
                end
                usart_pkg::RX_BITS: begin
                    if (rx_smp) begin
                        rx_sh_q[rx_idx_q] <= rx_bit;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_push)
                            rx_st_q <= usart_pkg::RX_IDLE;
                    end
                end
                default: rx_st_q <= usart_pkg::RX_IDLE;
            endcase
            if (!rx_en_q)
                rx_st_q <= usart_pkg::RX_IDLE;
        end
    end

    // two-entry fifo of {overrun, parity err, frame err, data}
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            rx_cnt_q <= 2'b00;
            dor_pend_q <= 1'b0;
        end else if (!rx_en_q) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            rx_cnt_q <= 2'b00;
            dor_pend_q <= 1'b0;
        end else begin
            if (rx_push && rx_cnt_q != 2'(usart_pkg::FIFO_DEPTH)) begin
                wr_ptr_q <= !wr_ptr_q;
                dor_pend_q <= 1'b0;
            end else if (rx_push) begin
                dor_pend_q <= 1'b1;
            end
            if (rd_data && rx_cnt_q != 2'b00)
                rd_ptr_q <= !rd_ptr_q;
            rx_cnt_q <= rx_cnt_q + 2'((rx_push && rx_cnt_q != 2'(usart_pkg::FIFO_DEPTH)))
                - 2'((rd_data && rx_cnt_q != 2'b00));
        end
    end
    // frame storage needs no reset: an entry is read only once it is counted
    always_ff @(posedge pclk) begin
        if (rx_en_q && rx_push && rx_cnt_q != 2'(usart_pkg::FIFO_DEPTH))
            fifo_q[wr_ptr_q] <= {dor_pend_q, rx_pe, rx_fe, rx_data};
    end
    assign rx_head = (rx_cnt_q != 2'b00) ? fifo_q[rd_ptr_q] : 12'h000;
    assign irq_rx_done = rx_ie_q && rx_cnt_q != 2'b00;

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !mapped;
            prdata_q <= 32'h0000_0000;
            case (paddr)
                usart_pkg::OFS_DATA: prdata_q[7:0] <= rx_head[7:0];
                usart_pkg::OFS_STAT_A: prdata_q[7:2] <= {rx_cnt_q != 2'b00, tx_done_q,
                    !tx_buf_full_q, rx_head[9], rx_head[11], rx_head[10]};
                usart_pkg::OFS_CTRL_B: prdata_q[7:0] <= {rx_ie_q, txc_ie_q, udre_ie_q,
                    rx_en_q, tx_en_q, csz2_q, rx_head[8], tx_ninth_q};
                usart_pkg::OFS_CTRL_C: prdata_q[6:1] <= {sync_q, par_en_q, par_odd_q,
                    stop2_q, csz_lo_q};
                usart_pkg::OFS_BAUD: prdata_q[15:0] <= baud_q;
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    a_buf_write_fills: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data && tx_en_q |=> tx_buf_full_q) else $error("write did not fill buffer");
    a_empty_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        udre_ie_q && !tx_buf_full_q |-> irq_tx_empty) else $error("empty request low");
    a_done_needs_empty: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_done_q) |-> !$past(tx_buf_full_q) && $past(tx_inflight_q))
        else $error("bad done");
    a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
        tx_done_ack && !txc_set |=> !tx_done_q) else $error("done not cleared");
    a_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_done_q) && txc_ie_q |-> irq_tx_done) else $error("done request missing");
    a_start_bit_out: assert property (@(posedge pclk) disable iff (!presetn)
        tx_load |=> !tx_out_q && tx_inflight_q) else $error("no start bit");
    a_disable_deferred: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_inflight_q || tx_buf_full_q) |=> serial_out_oe) else $error("pin dropped early");
    a_short_char_mask: assert property (@(posedge pclk) disable iff (!presetn)
        rx_push && nbits < 4'h8 |-> (rx_data >> nbits) == 9'h000) else $error("unmasked");
    a_flush_on_off: assert property (@(posedge pclk) disable iff (!presetn)
        !rx_en_q |=> rx_cnt_q == 2'b00 && !irq_rx_done) else $error("fifo not flushed");
    c_tx_done: cover property (@(posedge pclk) disable iff (!presetn) txc_set);
    c_rx_push: cover property (@(posedge pclk) disable iff (!presetn) rx_push);
    c_overrun: cover property (@(posedge pclk) disable iff (!presetn) rx_push && rx_cnt_q == 2'b10);
    c_back_to_back: cover property (@(posedge pclk) disable iff (!presetn)
        tx_load && tx_inflight_q);
endmodule
`default_nettype wire

// ==== verilog/usart_pkg.sv ====
// shared constants and types for the serial transmit/receive datapath
package usart_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_STAT_A = 8'h04;
    localparam logic [7:0] OFS_CTRL_B = 8'h08;
    localparam logic [7:0] OFS_CTRL_C = 8'h0C;
    localparam logic [7:0] OFS_BAUD = 8'h10;
    // serial_stat_a bit positions
    localparam int STA_RX_DONE = 7;
    localparam int STA_TX_DONE = 6;
    localparam int STA_TX_EMPTY = 5;
    localparam int STA_FRAME_ERR = 4;
    localparam int STA_OVERRUN = 3;
    localparam int STA_PAR_ERR = 2;
    // serial_ctrl_b bit positions
    localparam int CTB_RX_IE = 7;
    localparam int CTB_TX_DONE_IE = 6;
    localparam int CTB_TX_EMPTY_IE = 5;
    localparam int CTB_RX_EN = 4;
    localparam int CTB_TX_EN = 3;
    localparam int CTB_CSZ2 = 2;
    localparam int CTB_RX_NINTH = 1;
    localparam int CTB_TX_NINTH = 0;
    // serial_ctrl_c bit positions
    localparam int CTC_SYNC = 6;
    localparam int CTC_PAR_EN = 5;
    localparam int CTC_PAR_ODD = 4;
    localparam int CTC_STOP2 = 3;
    localparam int CTC_CSZ_LO = 1;
    // reset values
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] CTRL_C_RST = 8'h06;
    localparam logic [15:0] BAUD_RST = 16'h000F;
    // character size code for nine data bits
    localparam logic [2:0] CSZ_NINE = 3'h7;
    localparam logic [3:0] NBITS_BASE = 4'h5;
    localparam logic [3:0] NBITS_NINE = 4'h9;
    localparam int FIFO_DEPTH = 2;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_BITS = 3'b100
    } rx_state_e;
endpackage

// ==== dv/serial_station.sv ====
// remote serial station: drives the receive line, samples the transmit line
`timescale 1ns/1ps
`default_nettype none
module serial_station (
    input wire logic pclk,
    input wire logic tx_line,
    output logic rx_line,
    output logic bit_clk
);
    // line idles high (pulled up), link clock stands low outside frames
    initial begin
        rx_line = 1'b1;
        bit_clk = 1'b0;
    end

    // one frame lsb first; sync mode changes data on the rising link edge
    task automatic send(input logic [15:0] f, input int len, input bit sync, input int per);
        #7;
        for (int i = 0; i < len; i++) begin
            rx_line = f[i];
            if (sync) begin
                bit_clk = 1'b1;
                #100 bit_clk = 1'b0;
                #100;
            end else begin
                #(per * 25);
            end
        end
        rx_line = 1'b1;
    endtask

    // mid-bit sampling from the start edge; bits past len read as idle
    task automatic grab(input int len, input int per, output logic [15:0] f);
        int t;
        f = 16'hFFFF;
        t = 0;
        while (tx_line !== 1'b0 && t < 4000) begin
            @(posedge pclk);
            t++;
        end
        repeat (per / 2) @(posedge pclk);
        for (int i = 0; i < len; i++) begin
            f[i] = tx_line;
            repeat (per) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_usart_datapath.sv ====
// self-checking bench for the serial datapath over apb
`timescale 1ns/1ps
`default_nettype none
module tb_usart_datapath;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic tx_done_ack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, serial_in_pin, ext_bit_clock_pin, serial_out_pin, serial_out_oe;
    logic serial_in_owned, irq_tx_empty, irq_tx_done, irq_rx_done, err, pen, podd, st2;
    logic [15:0] fr, fr2, got;
    logic [8:0] d, d2;
    logic [7:0] m8;
    logic [2:0] csz;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 77559;
    int len, len2, n, t;

    always #12.5 pclk = ~pclk;

    usart_datapath i_usart_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
        .ext_bit_clock_pin(ext_bit_clock_pin), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .serial_in_owned(serial_in_owned),
        .irq_tx_empty(irq_tx_empty), .irq_tx_done(irq_tx_done), .irq_rx_done(irq_rx_done),
        .tx_done_ack(tx_done_ack));

    serial_station i_serial_station (.pclk(pclk), .tx_line(serial_out_pin),
        .rx_line(serial_in_pin), .bit_clk(ext_bit_clock_pin));

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // apb master: request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFF_FFFF);
        apb(1'b0, a, 32'h0);
        chk(nm, e & m, rv & m);
    endtask

    // expected line bits: start, data lsb first, parity, stop bits
    function automatic logic [15:0] mk_frame(input logic [8:0] dd, input int nb,
        input logic pe, input logic od, input logic s2, output int ln);
        logic [15:0] f;
        logic p;
        f = 16'hFFFE;
        p = od;
        ln = 1;
        for (int i = 0; i < nb; i++) begin
            f[ln] = dd[i];
            p = p ^ dd[i];
            ln++;
        end
        if (pe) begin
            f[ln] = p;
            ln++;
        end
        ln = ln + 1 + int'(s2);
        return f;
    endfunction

    // random format; nine-bit codes forced on the first two passes
    task automatic pick(input int k);
        csz = (k < 2) ? usart_pkg::CSZ_NINE : 3'($random(seed)) & 3'h3;
        d = 9'($random(seed));
        d2 = 9'($random(seed));
        pen = 1'($random(seed));
        podd = 1'($random(seed));
        st2 = 1'($random(seed));
        n = (csz == usart_pkg::CSZ_NINE) ? 9 : int'(csz) + 5;
        m8 = (n >= 8) ? 8'hFF : 8'hFF >> (8 - n);
        wr(usart_pkg::OFS_CTRL_C, {25'h0, 1'b0, pen, podd, st2, csz[1:0], 1'b0});
    endtask

    // watchdog: the whole run needs far fewer cycles
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl_b", usart_pkg::OFS_CTRL_B, 32'(usart_pkg::CTRL_B_RST));
        rdc("ctrl_c", usart_pkg::OFS_CTRL_C, 32'(usart_pkg::CTRL_C_RST));
        rdc("baud", usart_pkg::OFS_BAUD, 32'(usart_pkg::BAUD_RST));
        rdc("stat_a", usart_pkg::OFS_STAT_A, 32'h20);
        rdc("unmapped", 8'h14, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        wr(usart_pkg::OFS_BAUD, 32'h7);
        // transmit: nine-bit sizes then random sizes, random parity and stop choices, two ways to clear done
        for (int k = 0; k < 8; k++) begin
            pick(k);
            fr = mk_frame(d, n, pen, podd, st2, len);
            wr(usart_pkg::OFS_CTRL_B, 32'h78 | {29'h0, csz[2], 1'b0, d[8]});
            #1 chk("rx_owned", 32'h1, 32'(serial_in_owned));
            chk("irq_empty", 32'h1, 32'(irq_tx_empty));
            wr(usart_pkg::OFS_DATA, {24'h0, d[7:0]});
            #1 chk("irq_empty", 32'h0, 32'(irq_tx_empty));
            i_serial_station.grab(len, 8, got);
            chk("tx_frame", 32'(fr), 32'(got));
            for (t = 0; irq_tx_done !== 1'b1 && t < 100; t++) @(posedge pclk);
            chk("irq_done", 32'h1, 32'(irq_tx_done));
            rdc("stat_a", usart_pkg::OFS_STAT_A, 32'h60);
            if (k % 2 == 1) begin
                wr(usart_pkg::OFS_STAT_A, 32'h40);
            end else begin
                @(posedge pclk);
                tx_done_ack <= 1'b1;
                @(posedge pclk);
                tx_done_ack <= 1'b0;
            end
            @(posedge pclk);
            #1 chk("irq_done", 32'h0, 32'(irq_tx_done));
        end
        // disable while a frame is pending: pin kept until the frame is out
        wr(usart_pkg::OFS_CTRL_C, 32'h6);
        wr(usart_pkg::OFS_CTRL_B, 32'h18);
        wr(usart_pkg::OFS_DATA, 32'hA5);
        wr(usart_pkg::OFS_CTRL_B, 32'h10);
        #1 chk("tx_oe", 32'h1, 32'(serial_out_oe));
        fr = mk_frame(9'h0A5, 8, 1'b0, 1'b0, 1'b0, len);
        i_serial_station.grab(len, 8, got);
        chk("tx_frame", 32'(fr), 32'(got));
        for (t = 0; serial_out_oe !== 1'b0 && t < 100; t++) @(posedge pclk);
        chk("tx_oe", 32'h0, 32'(serial_out_oe));
        chk("tx_pin", 32'h1, 32'(serial_out_pin));
        wr(usart_pkg::OFS_STAT_A, 32'h40);
        // receive two frames, second in turn clean, with a parity fault or with a stop fault
        for (int k = 0; k < 6; k++) begin
            pick(k);
            if (k % 3 == 1) begin
                // parity on for both frames, so only the flipped bit is wrong
                pen = 1'b1;
                wr(usart_pkg::OFS_CTRL_C, {27'h1, podd, st2, csz[1:0], 1'b0});
            end
            fr = mk_frame(d, n, pen, podd, st2, len);
            fr2 = mk_frame(d2, n, pen, podd, st2, len2);
            if (k % 3 == 1) fr2[n + 1] = ~fr2[n + 1];
            if (k % 3 == 2) fr2[n + 1 + int'(pen)] = 1'b0;
            wr(usart_pkg::OFS_CTRL_B, 32'h90 | {29'h0, csz[2], 2'h0});
            i_serial_station.send(fr, len, 1'b0, 8);
            i_serial_station.send(fr2, len2, 1'b0, 8);
            #1 chk("irq_rx", 32'h1, 32'(irq_rx_done));
            rdc("stat_a", usart_pkg::OFS_STAT_A, 32'hA0);
            rdc("ninth", usart_pkg::OFS_CTRL_B, {30'h0, d[8], 1'b0}, {30'h0, n == 9, 1'b0});
            rdc("rx_data", usart_pkg::OFS_DATA, {24'h0, d[7:0] & m8});
            rdc("stat_a", usart_pkg::OFS_STAT_A,
                {24'h0, 3'h5, k % 3 == 2, 1'b0, k % 3 == 1, 2'h0});
            rdc("ninth", usart_pkg::OFS_CTRL_B, {30'h0, d2[8], 1'b0}, {30'h0, n == 9, 1'b0});
            rdc("rx_data", usart_pkg::OFS_DATA, {24'h0, d2[7:0] & m8});
            rdc("stat_a", usart_pkg::OFS_STAT_A, 32'h20);
        end
        // overrun: third frame dropped at full, next stored frame carries the flag
        repeat (3) i_serial_station.send(fr, len, 1'b0, 8);
        rdc("rx_data", usart_pkg::OFS_DATA, {24'h0, d[7:0] & m8});
        i_serial_station.send(fr, len, 1'b0, 8);
        rdc("stat_a", usart_pkg::OFS_STAT_A, 32'hA0);
        rdc("rx_data", usart_pkg::OFS_DATA, {24'h0, d[7:0] & m8});
        rdc("stat_a", usart_pkg::OFS_STAT_A, 32'hA8);
        // receiver disable releases the pin and flushes the frame still stored
        wr(usart_pkg::OFS_CTRL_B, 32'h0);
        #1 chk("rx_owned", 32'h0, 32'(serial_in_owned));
        rdc("stat_a", usart_pkg::OFS_STAT_A, 32'h20);
        // synchronous receive clocked from the link clock pin
        wr(usart_pkg::OFS_CTRL_C, 32'h46);
        wr(usart_pkg::OFS_CTRL_B, 32'h10);
        d = 9'($random(seed));
        fr = mk_frame(d, 8, 1'b0, 1'b0, 1'b0, len);
        i_serial_station.send(fr, len, 1'b1, 8);
        repeat (8) @(posedge pclk);
        rdc("stat_a", usart_pkg::OFS_STAT_A, 32'hA0);
        rdc("rx_data", usart_pkg::OFS_DATA, {24'h0, d[7:0]});
        wrap_up();
    end
endmodule
`default_nettype wire
